// ==== common/ssd_pkg.sv ====
package ssd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] SSD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SSD_STAT_OFS = 8'h04;
  localparam logic [7:0] SSD_DW2_OFS = 8'h08;
  localparam logic [7:0] SSD_DW8_OFS = 8'h20;
  localparam int SSD_NUM_DW = 7;
  localparam int SSD_FIRST_DW = 2;
  localparam int SSD_CTRL_COMMIT_BIT = 0;

  // ----------------------------------------------------------------
  // Field positions inside the packet dwords
  // ----------------------------------------------------------------
  localparam int SSD_WIND_BIT = 0;
  localparam int SSD_AA_BIT = 31;
  localparam int SSD_CULL_HI = 30;
  localparam int SSD_CULL_LO = 29;
  localparam int SSD_LW_HI = 27;
  localparam int SSD_LW_LO = 18;
  localparam int SSD_CAP_HI = 17;
  localparam int SSD_CAP_LO = 16;
  localparam int SSD_SCIS_BIT = 11;
  localparam int SSD_MS_HI = 9;
  localparam int SSD_MS_LO = 8;
  localparam int SSD_LASTPIX_BIT = 31;
  localparam int SSD_TRIPV_HI = 30;
  localparam int SSD_TRIPV_LO = 29;
  localparam int SSD_LINEPV_HI = 28;
  localparam int SSD_LINEPV_LO = 27;
  localparam int SSD_FANPV_HI = 26;
  localparam int SSD_FANPV_LO = 25;
  localparam int SSD_DIST_BIT = 14;
  localparam int SSD_SUBPIX_BIT = 12;
  localparam int SSD_PWSTATE_BIT = 11;
  localparam int SSD_PW_HI = 10;
  localparam int SSD_PW_LO = 0;
  localparam int SSD_OVR_X_BIT = 28;
  localparam int SSD_CSRC_HI = 26;
  localparam int SSD_CSRC_LO = 25;

  // ----------------------------------------------------------------
  // Encodings and constants
  // ----------------------------------------------------------------
  localparam logic [1:0] SSD_DISCARD_ALL_TRIANGLES = 2'h0;
  localparam logic [1:0] SSD_DISCARD_NO_TRIANGLES = 2'h1;
  localparam logic [1:0] SSD_DISCARD_FRONT_FACING = 2'h2;
  localparam logic [1:0] SSD_DISCARD_BACK_FACING = 2'h3;
  localparam logic [1:0] SSD_PV_RESERVED = 2'h3;
  localparam logic [9:0] SSD_LW_ONE_PIXEL = 10'h080;
  localparam logic [31:0] SSD_FLOAT_ONE = 32'h3f800000;
  localparam logic [31:0] SSD_RESET_WORD = 32'h00000000;

  typedef enum logic [2:0] {
    SSD_POINT = 3'h0,
    SSD_LINE_LIST_TOPOLOGY = 3'h1,
    SSD_LINE_STRIP_TOPOLOGY = 3'h2,
    SSD_TRI_LIST = 3'h3,
    SSD_TRI_STRIP = 3'h4,
    SSD_TRI_FAN = 3'h5,
    SSD_RECT = 3'h6
  } ssd_topo_type;

  // Primitive presented by the upstream setup logic
  typedef struct packed {
    logic valid;
    ssd_topo_type topo;
    logic screen_cw;
    logic last_in_strip;
    logic [31:0] primitive_identifier_vector;
    logic [3:0][31:0] attr1;
  } ssd_prim_in_type;

  // Per-primitive decisions for the rasteriser
  typedef struct packed {
    logic valid;
    logic discard;
    logic front_facing;
    logic [1:0] provoking_vertex;
    logic last_pixel;
    logic line_alpha_smoothing;
    logic [3:0][31:0] attr1;
  } ssd_prim_out_type;

  // Decoded setup state held for every later primitive
  typedef struct packed {
    logic winding_counterclockwise;
    logic [1:0] cull_mode;
    logic line_alpha_smoothing_enable;
    logic [9:0] line_width;
    logic [1:0] end_cap_width;
    logic scissor_enable;
    logic [1:0] multisample_mode;
    logic last_pixel_enable;
    logic [1:0] tri_provoke;
    logic [1:0] line_provoke;
    logic [1:0] fan_provoke;
    logic true_line_distance;
    logic subpixel_four_bits;
    logic point_width_from_state;
    logic [10:0] point_width;
    logic [31:0] depth_offset_constant;
    logic [31:0] depth_offset_scale;
    logic [31:0] depth_offset_clamp;
    logic [3:0] attr1_override;
    logic [1:0] override_vector_select;
  } ssd_state_type;

endpackage : ssd_pkg

// ==== design/ssd_setup_decode.sv ====
// Contract
// - Winding 0 makes clockwise triangles front facing, 1 counter-clockwise; triangles only.
// - Dword 3 bit 31 enables alpha line smoothing unless multisample raster is on.
// - Cull 0 drops all, 1 none, 2 front facing, 3 back facing triangles.
// - Culling touches only triangles; orientation comes from the winding setting.
// - Line width is unsigned 3.7 fixed point; zero means thinnest line.
// - End cap ramp code: 0.5, 1, 2 or 4 pixels.
// - Scissor test runs only while dword 3 bit 11 is set.
// - Last pixel lit for list lines, strip's final line, never wide or smoothed.
// - Triangle list and strip provoking vertex 0, 1, 2; 3 reserved.
// - Line provoking vertex 0 or 1; 2 and 3 reserved.
// - Triangle fan provoking vertex 0, 1, 2; 3 reserved.
// - Bit 14 picks line distance mode; 1 is true distance.
// - Bit 12: 0 keeps 8 subpixel bits, 1 keeps 4.
// - Dword 4 bit 11 sizes points from state width instead of vertex.
// - State point width is unsigned 8.3 fixed point pixels.
// - Depth offset constant, scale, clamp are whole float words in dwords 5-7.
// - Enabled W, Z, Y, X of attribute 1 come from the constant vector.
// - Constant vector: zeros, (0,0,0,1), ones, or replicated primitive id.
//
// Implementation choices: the Wishbone register port and the register addresses.
module ssd_setup_decode
  import ssd_pkg::*;
#(
  parameter logic [1:0] MS_ON_MASK = 2'h2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ssd_prim_in_type prim_i,
  output ssd_prim_out_type prim_o,
  output ssd_state_type state_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [SSD_NUM_DW-1:0][31:0] shadow;
    logic [15:0] commit_count;
    logic [15:0] prim_count;
    ssd_state_type act;
    ssd_prim_out_type res;
  } ssd_regs_type;

  ssd_regs_type st_ff;
  ssd_regs_type nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ssd_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : ssd_merge

  function automatic logic ssd_is_tri(input ssd_topo_type t);
    return (t == SSD_TRI_LIST) || (t == SSD_TRI_STRIP) || (t == SSD_TRI_FAN);
  endfunction : ssd_is_tri

  function automatic logic ssd_is_line(input ssd_topo_type t);
    return (t == SSD_LINE_LIST_TOPOLOGY) || (t == SSD_LINE_STRIP_TOPOLOGY);
  endfunction : ssd_is_line

  // Shadow word for packet dword n
  function automatic logic [31:0] ssd_dw(input ssd_regs_type s, input int n);
    return s.shadow[n - SSD_FIRST_DW];
  endfunction : ssd_dw

  // Decode the shadow dwords into the held setup state
  function automatic ssd_state_type ssd_decode(input ssd_regs_type s);
    ssd_state_type d;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [31:0] w4;
    logic [31:0] w8;
    w2 = ssd_dw(s, 2);
    w3 = ssd_dw(s, 3);
    w4 = ssd_dw(s, 4);
    w8 = ssd_dw(s, 8);
    d.winding_counterclockwise = w2[SSD_WIND_BIT];
    d.line_alpha_smoothing_enable = w3[SSD_AA_BIT];
    d.cull_mode = w3[SSD_CULL_HI:SSD_CULL_LO];
    d.line_width = w3[SSD_LW_HI:SSD_LW_LO];
    d.end_cap_width = w3[SSD_CAP_HI:SSD_CAP_LO];
    d.scissor_enable = w3[SSD_SCIS_BIT];
    d.multisample_mode = w3[SSD_MS_HI:SSD_MS_LO];
    d.last_pixel_enable = w4[SSD_LASTPIX_BIT];
    d.tri_provoke = w4[SSD_TRIPV_HI:SSD_TRIPV_LO];
    d.line_provoke = w4[SSD_LINEPV_HI:SSD_LINEPV_LO];
    d.fan_provoke = w4[SSD_FANPV_HI:SSD_FANPV_LO];
    d.true_line_distance = w4[SSD_DIST_BIT];
    d.subpixel_four_bits = w4[SSD_SUBPIX_BIT];
    d.point_width_from_state = w4[SSD_PWSTATE_BIT];
    d.point_width = w4[SSD_PW_HI:SSD_PW_LO];
    d.depth_offset_constant = ssd_dw(s, 5);
    d.depth_offset_scale = ssd_dw(s, 6);
    d.depth_offset_clamp = ssd_dw(s, 7);
    d.attr1_override = w8[SSD_OVR_X_BIT +: 4];
    d.override_vector_select = w8[SSD_CSRC_HI:SSD_CSRC_LO];
    return d;
  endfunction : ssd_decode

  // Constant vector, index 0 is X and 3 is W
  function automatic logic [3:0][31:0] ssd_const_vec(input logic [1:0] sel,
                                                     input logic [31:0] primitive_identifier_vector);
    logic [3:0][31:0] v;
    v = '0;
    case (sel)
      2'h0: v = '0;
      2'h1: v[3] = SSD_FLOAT_ONE;
      2'h2: v = {4{SSD_FLOAT_ONE}};
      2'h3: v = {4{primitive_identifier_vector}};
      default: v = '0;
    endcase
    return v;
  endfunction : ssd_const_vec

  // Reserved provoking codes fall back to vertex 0
  function automatic logic [1:0] ssd_pv_fix(input logic [1:0] code, input logic line);
    logic [1:0] r;
    r = code;
    if (line && code[1]) begin
      r = 2'h0;
    end else if (code == SSD_PV_RESERVED) begin
      r = 2'h0;
    end
    return r;
  endfunction : ssd_pv_fix

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic bus_req;
  logic in_dw_range;
  logic [2:0] dw_idx;
  logic front;
  logic aa_eff;
  logic wide_line;
  logic is_tri;
  logic line;
  logic [3:0][31:0] cvec;

  always_comb begin
    nxt_st = st_ff;
    bus_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    in_dw_range = (wb_adr_i >= SSD_DW2_OFS) && (wb_adr_i <= SSD_DW8_OFS)
                  && (wb_adr_i[1:0] == 2'h0);
    dw_idx = 3'(wb_adr_i[7:2] - SSD_DW2_OFS[7:2]);

    // Bus slave: one wait state, ack for a single cycle
    nxt_st.ack = bus_req;
    if (bus_req) begin
      nxt_st.rdata = SSD_RESET_WORD;
      if (wb_we_i) begin
        if (in_dw_range) begin
          nxt_st.shadow[dw_idx] = ssd_merge(st_ff.shadow[dw_idx], wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == SSD_CTRL_OFS && wb_sel_i[0]
                     && wb_dat_i[SSD_CTRL_COMMIT_BIT]) begin
          nxt_st.act = ssd_decode(st_ff);
          nxt_st.commit_count = st_ff.commit_count + 16'h0001;
        end
      end else begin
        if (in_dw_range) begin
          nxt_st.rdata = st_ff.shadow[dw_idx];
        end else if (wb_adr_i == SSD_STAT_OFS) begin
          nxt_st.rdata = {st_ff.prim_count, st_ff.commit_count};
        end
      end
    end

    // Primitive path, always using the latched state
    is_tri = ssd_is_tri(prim_i.topo);
    line = ssd_is_line(prim_i.topo);
    front = is_tri && (prim_i.screen_cw != st_ff.act.winding_counterclockwise);
    aa_eff = st_ff.act.line_alpha_smoothing_enable
             && ((st_ff.act.multisample_mode & MS_ON_MASK) == 2'h0);
    wide_line = st_ff.act.line_width > SSD_LW_ONE_PIXEL;
    cvec = ssd_const_vec(st_ff.act.override_vector_select, prim_i.primitive_identifier_vector);

    nxt_st.res.valid = prim_i.valid;
    nxt_st.res.front_facing = front;
    nxt_st.res.line_alpha_smoothing = line && aa_eff;
    nxt_st.res.discard = 1'b0;
    if (is_tri) begin
      case (st_ff.act.cull_mode)
        SSD_DISCARD_ALL_TRIANGLES: nxt_st.res.discard = 1'b1;
        SSD_DISCARD_NO_TRIANGLES: nxt_st.res.discard = 1'b0;
        SSD_DISCARD_FRONT_FACING: nxt_st.res.discard = front;
        SSD_DISCARD_BACK_FACING: nxt_st.res.discard = !front;
        default: nxt_st.res.discard = 1'b0;
      endcase
    end

    nxt_st.res.last_pixel = st_ff.act.last_pixel_enable && line && !wide_line && !aa_eff
                            && (prim_i.topo == SSD_LINE_LIST_TOPOLOGY || prim_i.last_in_strip);

    case (prim_i.topo)
      SSD_TRI_LIST, SSD_TRI_STRIP: begin
        nxt_st.res.provoking_vertex = ssd_pv_fix(st_ff.act.tri_provoke, 1'b0);
      end
      SSD_LINE_LIST_TOPOLOGY, SSD_LINE_STRIP_TOPOLOGY: begin
        nxt_st.res.provoking_vertex = ssd_pv_fix(st_ff.act.line_provoke, 1'b1);
      end
      SSD_TRI_FAN: begin
        nxt_st.res.provoking_vertex = ssd_pv_fix(st_ff.act.fan_provoke, 1'b0);
      end
      default: begin
        nxt_st.res.provoking_vertex = 2'h0;
      end
    endcase

    for (int c = 0; c < 4; c++) begin
      nxt_st.res.attr1[c] = st_ff.act.attr1_override[c] ? cvec[c] : prim_i.attr1[c];
    end

    if (prim_i.valid) begin
      nxt_st.prim_count = st_ff.prim_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign prim_o = st_ff.res;
  assign state_o = st_ff.act;

endmodule : ssd_setup_decode

// ==== verification/ssd_prim_src.sv ====
// ----
// Command streamer stand-in: one primitive per send
// ----
module ssd_prim_src
  import ssd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic send,
  input wire ssd_topo_type topo,
  input wire logic cw,
  input wire logic last,
  input wire logic [31:0] id,
  output ssd_prim_in_type prim_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prim_ff <= '0;
    end else if (send) begin
      prim_ff.valid <= 1'b1;
      prim_ff.topo <= topo;
      prim_ff.screen_cw <= cw;
      prim_ff.last_in_strip <= last;
      prim_ff.primitive_identifier_vector <= id;
      for (int i = 0; i < 4; i++) begin
        prim_ff.attr1[i] <= {id[27:0], 4'(i)};
      end
    end else begin
      // Idle fields flip so stale data never looks valid
      prim_ff <= ssd_prim_in_type'({1'b0, ~prim_ff[$bits(ssd_prim_in_type)-2:0]});
    end
  end
endmodule : ssd_prim_src

// ==== verification/ssd_setup_decode_asserts.sv ====
module ssd_setup_decode_asserts
  import ssd_pkg::*;
#(
  parameter logic [1:0] MS_ON_MASK = 2'h2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ssd_prim_in_type prim_i,
  input wire ssd_prim_out_type prim_o,
  input wire ssd_state_type state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Helpers and checks
  // ----
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic tri_in;
  logic commit;
  logic exp_front;
  assign tri_in = prim_i.valid && prim_i.topo inside {SSD_TRI_LIST, SSD_TRI_STRIP, SSD_TRI_FAN};
  // Commit lands at the edge that takes the request, while ack is still low
  assign commit = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == SSD_CTRL_OFS
    && wb_sel_i[0] && wb_dat_i[SSD_CTRL_COMMIT_BIT];
  assign exp_front = prim_i.screen_cw ^ state_o.winding_counterclockwise;
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  state_hold_a: assert property (!$stable(state_o) |-> $past(commit))
    else $error("state moved without commit");
  prim_valid_a: assert property (prim_o.valid == $past(prim_i.valid))
    else $error("primitive valid lost");
  cull_all_a: assert property (tri_in && state_o.cull_mode == 2'h0 |=> prim_o.discard)
    else $error("triangle not discarded");
  no_cull_a: assert property (prim_i.valid && !tri_in
    |=> !prim_o.discard && !prim_o.front_facing) else $error("non triangle culled");
  facing_a: assert property (tri_in |=> prim_o.front_facing == $past(exp_front))
    else $error("facing wrong");
  ms_smooth_a: assert property (prim_i.valid && (state_o.multisample_mode & MS_ON_MASK) != 2'h0
    |=> !prim_o.line_alpha_smoothing) else $error("smoothing under multisample");
  attr_pass_a: assert property (prim_i.valid && !state_o.attr1_override[0]
    |=> prim_o.attr1[0] == $past(prim_i.attr1[0])) else $error("attribute x altered");
  cover property (commit);
  cover property (tri_in && state_o.cull_mode == SSD_DISCARD_BACK_FACING);
  cover property (prim_o.valid && prim_o.last_pixel);
endmodule : ssd_setup_decode_asserts

bind ssd_setup_decode ssd_setup_decode_asserts #(.MS_ON_MASK(MS_ON_MASK)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prim_i(prim_i), .prim_o(prim_o),
  .state_o(state_o)
);

// ==== verification/tb_setup_stage_state_decode.sv ====
module tb_setup_stage_state_decode
  import ssd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] MS_MASK = 2'h2;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wd = 32'h0;
  logic [31:0] wb_rd;
  logic wb_ack;
  logic send = 1'b0;
  ssd_topo_type topo = SSD_POINT;
  logic cw = 1'b0;
  logic last = 1'b0;
  logic [31:0] id = 32'h0;
  ssd_prim_in_type prim_i;
  ssd_prim_out_type prim_o;
  ssd_state_type state_o;
  int failures = 0;
  int checks = 0;

  ssd_prim_src u_src (.ref_clk(ref_clk), .rst_b(rst_b), .send(send), .topo(topo), .cw(cw),
    .last(last), .id(id), .prim_ff(prim_i));
  ssd_setup_decode #(.MS_ON_MASK(MS_MASK)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .prim_i(prim_i), .prim_o(prim_o), .state_o(state_o));

  always #4 ref_clk = ~ref_clk;

  // ----
  // Shared tasks
  // ----
  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wd <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask : wr

  task automatic cfg(input logic [31:0] d2, d3, d4, d8);
    wr(SSD_DW2_OFS, d2);
    wr(8'h0c, d3);
    wr(8'h10, d4);
    wr(SSD_DW8_OFS, d8);
    wr(SSD_CTRL_OFS, 32'h1);
  endtask : cfg

  task automatic prim(input ssd_topo_type t, input logic c, input logic l);
    @(posedge ref_clk);
    send <= 1'b1;
    topo <= t;
    cw <= c;
    last <= l;
    id <= id + 32'h11;
    @(posedge ref_clk);
    send <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : prim

  // ----
  // Scenarios
  // ----
  task automatic s_fields;
    logic [31:0] q;
    ssd_state_type e;
    wb(1'b1, 8'hfc, 32'hffffffff, q);
    wb(1'b0, 8'hfc, 32'h0, q);
    check(q, 32'h0);
    wr(8'h14, 32'h3f800000);
    wr(8'h18, 32'hc0490fdb);
    wr(8'h1c, 32'h7f7fffff);
    check(state_o, '0);
    // Multisample mode mirrors the pixel stage copy; targets are float
    cfg(32'h1, 32'hefee0900, 32'hca005da3, 32'hb4000000);
    e = '{winding_counterclockwise:1'b1, cull_mode:2'h3, line_alpha_smoothing_enable:1'b1,
      line_width:10'h3fb, end_cap_width:2'h2, scissor_enable:1'b1, multisample_mode:2'h1,
      last_pixel_enable:1'b1, tri_provoke:2'h2, line_provoke:2'h1, fan_provoke:2'h1,
      true_line_distance:1'b1, subpixel_four_bits:1'b1, point_width_from_state:1'b1,
      point_width:11'h5a3, depth_offset_constant:32'h3f800000,
      depth_offset_scale:32'hc0490fdb, depth_offset_clamp:32'h7f7fffff,
      attr1_override:4'hb, override_vector_select:2'h2};
    check(state_o, e);
    wb(1'b0, 8'h0c, 32'h0, q);
    check(q, 32'hefee0900);
    wb(1'b0, SSD_STAT_OFS, 32'h0, q);
    check(q, 32'h00000001);
  endtask : s_fields

  task automatic s_cull;
    logic ff;
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 4; m++) begin
        cfg(32'(w), {1'b0, 2'(m), 29'h0}, 32'h0, 32'h0);
        for (int c = 0; c < 2; c++) begin
          prim(SSD_TRI_LIST, c[0], 1'b0);
          ff = c[0] ^ w[0];
          check(prim_o.front_facing, ff);
          check(prim_o.discard, m == 0 || (m == 2 && ff) || (m == 3 && !ff));
        end
        prim(SSD_LINE_LIST_TOPOLOGY, 1'b1, 1'b0);
        check(prim_o.discard, 1'b0);
        check(prim_o.front_facing, 1'b0);
        prim(SSD_RECT, 1'b1, 1'b0);
        check(prim_o.discard, 1'b0);
      end
    end
  endtask : s_cull

  task automatic s_provoke;
    for (int c = 0; c < 4; c++) begin
      cfg(32'h0, 32'h20000000, {1'b0, 2'(c), 2'(c), 2'(c), 25'h0}, 32'h0);
      prim(SSD_TRI_STRIP, 1'b0, 1'b0);
      check(prim_o.provoking_vertex, (c == 3) ? 2'h0 : 2'(c));
      prim(SSD_TRI_FAN, 1'b0, 1'b0);
      check(prim_o.provoking_vertex, (c == 3) ? 2'h0 : 2'(c));
      prim(SSD_LINE_STRIP_TOPOLOGY, 1'b0, 1'b1);
      check(prim_o.provoking_vertex, (c > 1) ? 2'h0 : 2'(c));
    end
  endtask : s_provoke

  task automatic s_lines;
    cfg(32'h0, 32'h20000000, 32'h80000000, 32'h0);
    prim(SSD_LINE_LIST_TOPOLOGY, 1'b0, 1'b0);
    check(prim_o.last_pixel, 1'b1);
    prim(SSD_LINE_STRIP_TOPOLOGY, 1'b0, 1'b0);
    check(prim_o.last_pixel, 1'b0);
    prim(SSD_LINE_STRIP_TOPOLOGY, 1'b0, 1'b1);
    check(prim_o.last_pixel, 1'b1);
    cfg(32'h0, 32'h24000000, 32'h80000000, 32'h0);
    prim(SSD_LINE_LIST_TOPOLOGY, 1'b0, 1'b0);
    check(prim_o.last_pixel, 1'b0);
    for (int ms = 0; ms < 4; ms++) begin
      cfg(32'h0, 32'ha0000000 | (ms << 8), 32'h80000000, 32'h0);
      prim(SSD_LINE_LIST_TOPOLOGY, 1'b0, 1'b0);
      check(prim_o.line_alpha_smoothing, (2'(ms) & MS_MASK) == 2'h0);
      // Multisample on drops smoothing, so the thin line gets its last pixel again
      check(prim_o.last_pixel, (2'(ms) & MS_MASK) != 2'h0);
    end
  endtask : s_lines

  task automatic s_attr;
    logic [31:0] v;
    for (int s = 0; s < 4; s++) begin
      cfg(32'h0, 32'h20000000, 32'h0, {4'hd, 1'b0, 2'(s), 25'h0});
      prim(SSD_POINT, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
        v = (s == 3) ? id : (s == 2 || (s == 1 && i == 3)) ? SSD_FLOAT_ONE : 32'h0;
        check(prim_o.attr1[i], (i == 1) ? {id[27:0], 4'(i)} : v);
      end
    end
  endtask : s_attr

  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    s_fields();
    s_cull();
    s_provoke();
    s_lines();
    s_attr();
    end_sim();
  end
endmodule : tb_setup_stage_state_decode
